/* File: hw/gpio_port.sv */
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.svh"

module gpio_port
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pads
  input wire logic [7:0] pad_i,
  output logic [7:0] pad_o,
  output logic [7:0] pad_oe_o,
  output logic [7:0] pad_pu_o,
  // peripheral alternate functions
  input wire logic [7:0] af_oe_i,
  input wire logic [7:0] af_out_i,
  output logic [7:0] af_in_o,
  // processor side
  input wire logic cpu_imask_i,
  input wire logic [6:0] vec_fetch_i,
  output logic [6:0] irq_o
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // merge write data into a register under the byte enables
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // level of each pin as seen by one vector; unselected pins read high
  function automatic logic [7:0] vec_levels(
    input logic [2:0] vec,
    input logic [7:0] int_en,
    input logic [23:0] vsel,
    input logic [7:0] lvl
  );
    logic [7:0] res;
    res = 8'hFF;
    for (int p = 0; p < `NUM_PINS; p++) begin
      if (int_en[p] && vsel[p*`VSEL_W +: `VSEL_W] == vec) begin
        res[p] = lvl[p];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // declarations

  port_s st_q;
  port_s st_d;
  logic [7:0] pin_lvl;
  logic [6:0] pend;
  logic [7:0] int_en;
  logic req;
  logic wr;
  logic sens_chg;
  logic [31:0] wmerged;
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////
  // pad input synchroniser

  pin_sync i_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pad_i(pad_i),
    .lvl_o(pin_lvl)
  );

  ////////////////////////////////////////////////////////////////////
  // external interrupt vectors

  // interrupt input: pin is input with option set and capable
  assign int_en = ~st_q.dir & st_q.opt & `INT_CAPABLE;

  // sensitivity write that changes the value clears every vector
  assign sens_chg = wr && adr_i == `OFS_SENS &&
    wmerged[13:0] != st_q.sens;

  for (genvar v = 0; v < `NUM_VEC; v++) begin : g_vec
    eint_vec i_eint_vec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lvl_i(vec_levels(3'(v), int_en, st_q.vsel, pin_lvl)),
      .sens_i(st_q.sens[v*`SENS_W +: `SENS_W]),
      .clr_i(vec_fetch_i[v] | sens_chg),
      .pend_o(pend[v])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // bus decode

  // a request is taken once; ack stands for one cycle
  assign req = cyc_i & stb_i & ~st_q.ack;
  assign wr = req & we_i;

  // old value of the addressed register, zero elsewhere
  always_comb begin
    rd = 32'h00000000;
    if (adr_i == `OFS_DATA) begin
      rd[7:0] = st_q.latch;
    end else if (adr_i == `OFS_DIR) begin
      rd[7:0] = st_q.dir;
    end else if (adr_i == `OFS_OPT) begin
      rd[7:0] = st_q.opt;
    end else if (adr_i == `OFS_SENS) begin
      rd[13:0] = st_q.sens;
    end else if (adr_i == `OFS_VSEL) begin
      rd[23:0] = st_q.vsel;
    end else if (adr_i == `OFS_PEND) begin
      rd[6:0] = pend;
    end
  end

  assign wmerged = merge(rd, dat_i, sel_i);

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    st_d.ack = req;

    // register writes; the data latch is written in any direction
    if (wr) begin
      if (adr_i == `OFS_DATA) begin
        st_d.latch = wmerged[7:0];
      end else if (adr_i == `OFS_DIR) begin
        st_d.dir = wmerged[7:0];
      end else if (adr_i == `OFS_OPT) begin
        st_d.opt = wmerged[7:0];
      end else if (adr_i == `OFS_SENS) begin
        st_d.sens = wmerged[13:0];
      end else if (adr_i == `OFS_VSEL) begin
        st_d.vsel = wmerged[23:0];
      end
    end

    // read data; data register mixes pin and latch per bit
    if (req && !we_i) begin
      st_d.rdata = rd;
      if (adr_i == `OFS_DATA) begin
        for (int p = 0; p < `NUM_PINS; p++) begin
          if (af_oe_i[p] || !st_q.dir[p]) begin
            st_d.rdata[p] = pin_lvl[p];
          end else begin
            st_d.rdata[p] = st_q.latch[p];
          end
        end
      end
    end else begin
      st_d.rdata = 32'h00000000;
    end

    // pad drive per pin
    for (int p = 0; p < `NUM_PINS; p++) begin
      if (af_oe_i[p]) begin
        st_d.pad_oe[p] = 1'b1;
        st_d.pad_out[p] = af_out_i[p];
        st_d.pad_pu[p] = 1'b0;
      end else if (st_q.dir[p]) begin
        st_d.pad_pu[p] = 1'b0;
        if (st_q.opt[p]) begin
          st_d.pad_oe[p] = 1'b1;
          st_d.pad_out[p] = st_q.latch[p];
        end else begin
          st_d.pad_oe[p] = ~st_q.latch[p];
          st_d.pad_out[p] = 1'b0;
        end
      end else begin
        st_d.pad_oe[p] = 1'b0;
        st_d.pad_out[p] = 1'b0;
        st_d.pad_pu[p] = st_q.opt[p];
      end
      // output pins feed the peripheral from the latch
      st_d.af_in[p] = st_q.dir[p] ? st_q.latch[p] : pin_lvl[p];
    end

    // requests gated by the processor's global mask
    st_d.irq = cpu_imask_i ? 7'h00 : pend;
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.latch <= `RST_DATA;
      st_q.dir <= `RST_DIR;
      st_q.opt <= `RST_OPT;
      st_q.sens <= `RST_SENS;
      st_q.vsel <= `RST_VSEL;
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h00000000;
      st_q.pad_out <= 8'h00;
      st_q.pad_oe <= 8'h00;
      st_q.pad_pu <= 8'h00;
      st_q.af_in <= 8'h00;
      st_q.irq <= 7'h00;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign dat_o = st_q.rdata;
  assign ack_o = st_q.ack;
  assign pad_o = st_q.pad_out;
  assign pad_oe_o = st_q.pad_oe;
  assign pad_pu_o = st_q.pad_pu;
  assign af_in_o = st_q.af_in;
  assign irq_o = st_q.irq;

endmodule
`default_nettype wire

/* File: include/gpio_map.svh */
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// register byte offsets on the bus
`define OFS_DATA 8'h00
`define OFS_DIR 8'h04
`define OFS_OPT 8'h08
`define OFS_SENS 8'h0C
`define OFS_VSEL 8'h10
`define OFS_PEND 8'h14

// reset values
`define RST_DATA 8'hFF
`define RST_DIR 8'h00
`define RST_OPT 8'h00
`define RST_SENS 14'h0000
`define RST_VSEL 24'hFFFFFF
`define RST_PIN 8'hFF

// field layout
`define NUM_PINS 8
`define NUM_VEC 7
`define VSEL_W 3
`define SENS_W 2
`define VSEL_NONE 3'h7
`define INT_CAPABLE 8'hFF

`endif

/* File: include/gpio_pkg.sv */
package gpio_pkg;

  // sensitivity codes, one field per interrupt vector
  typedef enum logic [1:0] {
    SENS_FALL_LOW = 2'h0,
    SENS_RISE = 2'h1,
    SENS_FALL = 2'h2,
    SENS_BOTH = 2'h3
  } sens_e;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
  } sync_s;

  typedef struct packed {
    logic prev;
    logic pend;
  } vec_s;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] opt;
    logic [13:0] sens;
    logic [23:0] vsel;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pu;
    logic [7:0] af_in;
    logic [6:0] irq;
  } port_s;

endpackage

/* File: hw/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.svh"

module pin_sync
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pad_i,
  output logic [7:0] lvl_o
);

  sync_s st_q;
  sync_s st_d;

  // three stages; level moves only where stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pad_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '{s1: `RST_PIN, s2: `RST_PIN, s3: `RST_PIN, lvl: `RST_PIN};
    end else begin
      st_q <= st_d;
    end
  end

  assign lvl_o = st_q.lvl;

endmodule
`default_nettype wire

/* File: hw/eint_vec.sv */
`timescale 1ns/100ps
`default_nettype none

module eint_vec
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] lvl_i,
  input wire logic [1:0] sens_i,
  input wire logic clr_i,
  output logic pend_o
);

  vec_s st_q;
  vec_s st_d;
  logic comb_lvl;
  logic set;

  // selected pins are and-ed, so one pin held low masks the rest
  always_comb begin
    comb_lvl = &lvl_i;
    set = 1'b0;
    case (sens_e'(sens_i))
      SENS_FALL_LOW: set = ~comb_lvl;
      SENS_RISE: set = comb_lvl & ~st_q.prev;
      SENS_FALL: set = ~comb_lvl & st_q.prev;
      default: set = comb_lvl ^ st_q.prev;
    endcase
    st_d.prev = comb_lvl;
    st_d.pend = set | (st_q.pend & ~clr_i);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '{prev: 1'b1, pend: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign pend_o = st_q.pend;

endmodule
`default_nettype wire

/* File: test/pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_model
  import gpio_pkg::*;
(
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] lvl_o
);
  ////////////////////////////////
  // port drive wins, then outside driver, then pull-up; a bare pin shows the inverse
  always_comb begin
    lvl_o = oe_i & drv_i;
    lvl_o |= ~oe_i & ext_en_i & ext_val_i;
    lvl_o |= ~oe_i & ~ext_en_i & pu_i;
    lvl_o |= ~oe_i & ~ext_en_i & ~pu_i & ~drv_i;
  end
endmodule

`default_nettype wire

/* File: test/gpio_port_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

module gpio_port_asserts
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [7:0] pad_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pad_pu_o,
  input wire logic [7:0] af_oe_i,
  input wire logic [7:0] af_out_i,
  input wire logic cpu_imask_i,
  input wire logic [6:0] vec_fetch_i,
  input wire logic [6:0] irq_o
);
  ////////////////////////////////
  // no fetch, mask or bus write on vector 0
  logic quiet;
  assign quiet = !vec_fetch_i[0] && !cpu_imask_i && !(cyc_i && stb_i && we_i);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////
  // bus handshake
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  property p_ack_resp;
    s_req |=> ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

  ////////////////////////////////
  // pins and interrupts
  property p_mask;
    cpu_imask_i |=> irq_o == 7'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("request passed while masked");
  property p_af_oe;
    !$past(rst_i) |-> (pad_oe_o & $past(af_oe_i)) == $past(af_oe_i);
  endproperty
  a_af_oe: assert property (p_af_oe) else $error("peripheral enable lost");
  property p_af_out;
    !$past(rst_i) |-> ((pad_o ^ $past(af_out_i)) & $past(af_oe_i)) == 8'h00;
  endproperty
  a_af_out: assert property (p_af_out) else $error("peripheral value lost");
  property p_pu_in;
    (pad_pu_o & pad_oe_o) == 8'h00;
  endproperty
  a_pu_in: assert property (p_pu_in) else $error("pull-up on driven pin");
  property p_pend_hold;
    irq_o[0] && quiet && $past(quiet) |=> irq_o[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("request dropped");
endmodule

bind gpio_port gpio_port_asserts i_gpio_port_asserts(.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o), .af_oe_i(af_oe_i),
  .af_out_i(af_out_i), .cpu_imask_i(cpu_imask_i), .vec_fetch_i(vec_fetch_i),
  .irq_o(irq_o));

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end

module tb_top
  import gpio_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic cpu_imask_i = 1'b0, ack_o;
  logic [7:0] adr_i = 8'h00, pad_i, pad_o, pad_oe_o, pad_pu_o, af_in_o;
  logic [7:0] af_oe_i = 8'h00, af_out_i = 8'h00, ext_en = 8'hFF, ext_val = 8'hFF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [6:0] vec_fetch_i = 7'h00, irq_o;
  int mismatches = 0, total_checks = 0, cycles = 0;

  ////////////////////////////////
  // clock, device and pins
  always #5 clk_i = ~clk_i;
  gpio_port i_gpio_port(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
    .pad_pu_o(pad_pu_o), .af_oe_i(af_oe_i), .af_out_i(af_out_i), .af_in_o(af_in_o),
    .cpu_imask_i(cpu_imask_i), .vec_fetch_i(vec_fetch_i), .irq_o(irq_o));
  pin_model i_pin_model(.drv_i(pad_o), .oe_i(pad_oe_o), .pu_i(pad_pu_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pad_i));

  ////////////////////////////////
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////
  // bus cycle, read compare, waits
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wirq(input logic v);
    int n;
    for (n = 0; n < 30 && irq_o[0] !== v; n++) @(posedge clk_i);
    `CHK("irq0", v, irq_o[0])
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////
  // test sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `OFS_PEND, 32'h7F);
    rc(`OFS_DATA, 32'hFF, "data");
    rc(`OFS_DIR, 32'(`RST_DIR), "dir");
    rc(`OFS_OPT, 32'(`RST_OPT), "opt");
    rc(`OFS_SENS, 32'(`RST_SENS), "sens");
    rc(`OFS_VSEL, 32'(`RST_VSEL), "vsel");
    rc(`OFS_PEND, 32'h0, "pend");
    rc(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    wb(1'b1, `OFS_DIR, 32'hFF);
    wb(1'b1, `OFS_OPT, 32'h0F);
    ext_en <= 8'h00;
    wb(1'b1, `OFS_DATA, 32'h5A);
    `CHK("oe", 8'hAF, pad_oe_o)
    `CHK("out", 8'h0A, pad_o)
    rc(`OFS_DATA, 32'h5A, "latch");
    $display("test output done");
    ext_en <= 8'hFF;
    ext_val <= 8'h3C;
    wb(1'b1, `OFS_DIR, 32'h00);
    wb(1'b1, `OFS_OPT, 32'hF0);
    wb(1'b1, `OFS_DATA, 32'h00);
    `CHK("pu", 8'hF0, pad_pu_o)
    `CHK("in oe", 8'h00, pad_oe_o)
    rc(`OFS_DATA, 32'h3C, "pin");
    `CHK("af in", 8'h3C, af_in_o)
    $display("test input done");
    ext_en <= 8'hFE;
    af_oe_i <= 8'h01;
    af_out_i <= 8'h01;
    tk(6);
    `CHK("af oe", 8'h01, pad_oe_o & 8'h01)
    rc(`OFS_DATA, 32'h3D, "af pin");
    af_oe_i <= 8'h00;
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    $display("test alternate done");
    wb(1'b1, `OFS_VSEL, 32'hFFFFC0);
    wb(1'b1, `OFS_OPT, 32'h03);
    wb(1'b1, `OFS_SENS, 32'(SENS_FALL));
    ext_val <= 8'hFE;
    wirq(1'b1);
    rc(`OFS_PEND, 32'h1, "pend");
    cpu_imask_i <= 1'b1;
    tk(3);
    `CHK("masked", 7'h00, irq_o)
    cpu_imask_i <= 1'b0;
    vec_fetch_i <= 7'h01;
    tk(1);
    vec_fetch_i <= 7'h00;
    tk(3);
    rc(`OFS_PEND, 32'h0, "fetch");
    ext_val <= 8'hFC;
    tk(8);
    ext_val <= 8'hFD;
    tk(8);
    rc(`OFS_PEND, 32'h0, "and");
    ext_val <= 8'hFF;
    tk(8);
    ext_val <= 8'hFE;
    wirq(1'b1);
    wb(1'b1, `OFS_SENS, 32'(SENS_RISE));
    rc(`OFS_PEND, 32'h0, "sens clr");
    ext_val <= 8'hFF;
    wirq(1'b1);
    rc(`OFS_PEND, 32'h1, "rise");
    wb(1'b1, `OFS_SENS, 32'(SENS_BOTH));
    rc(`OFS_PEND, 32'h0, "both clr");
    ext_val <= 8'hFE;
    wirq(1'b1);
    rc(`OFS_PEND, 32'h1, "both");
    wb(1'b1, `OFS_SENS, 32'(SENS_FALL_LOW));
    rc(`OFS_PEND, 32'h1, "level");
    vec_fetch_i <= 7'h01;
    tk(1);
    vec_fetch_i <= 7'h00;
    tk(3);
    rc(`OFS_PEND, 32'h1, "level hold");
    $display("test interrupt done");
    end_of_test();
  end
endmodule

`default_nettype wire
